// *** hdl/phmp_cfg.svh ***
// constants for the parallel host message port: selects, fields, resets
// assumes inclusion by its bare name from the package and design files
`ifndef PHMP_CFG_SVH
`define PHMP_CFG_SVH

// ----------------------------------------------------------------------
// register select codes on the two address pins
// ----------------------------------------------------------------------
`define PHMP_SEL_MSG       2'h0
`define PHMP_SEL_CTRL      2'h1
`define PHMP_SEL_AUD1      2'h2
`define PHMP_SEL_AUD2      2'h3

// ----------------------------------------------------------------------
// port_control field positions
// ----------------------------------------------------------------------
`define PHMP_CTL_PEND_BIT  1
`define PHMP_CTL_BUSY_BIT  2
`define PHMP_CTL_BSEL_LO   3
`define PHMP_CTL_BSEL_HI   4

// ----------------------------------------------------------------------
// reset values and byte counts
// ----------------------------------------------------------------------
`define PHMP_BSEL_RST      2'h3
`define PHMP_BYTE_RST      8'h00
`define PHMP_WORD_RST      32'h0000_0000
`define PHMP_CNT_FIRST     2'h0
`define PHMP_CNT_LAST      2'h3
`define PHMP_CNT_STEP      2'h1
`define PHMP_PIN_RST       13'h1C00
`define PHMP_STB_IDLE      3'h7

`endif

// *** hdl/phmp_pkg.sv ***
// types shared by the parallel host message port files
// assumes phmp_cfg.svh is on the include path
package phmp_pkg;
    `include "phmp_cfg.svh"

    // register select carried from the address pins
    typedef logic [1:0] phmp_sel_type;
    // one byte of the host data bus
    typedef logic [7:0] phmp_byte_type;
    // one assembled message word
    typedef logic [31:0] phmp_word_type;
endpackage

// *** hdl/phmp_sync.sv ***
// three-stage synchroniser for the asynchronous host pins
// assumes the pins are quiet around reset release
`timescale 1ns/100ps
module phmp_sync #(
    parameter int            WIDTH    = 13,
    parameter logic [12:0]   RST_VAL  = 13'h1C00
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // raw pins
    input  wire logic [WIDTH-1:0] pin_raw,
    // second and third stage
    output logic      [WIDTH-1:0] pin_s2,
    output logic      [WIDTH-1:0] pin_s3
);
    import phmp_pkg::*;

    logic [WIDTH-1:0] pin_s1_q;

    // --------------------------------------------------------------
    // chain
    // --------------------------------------------------------------
    // stage one feeds only stage two, so metastability cannot spread
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q <= RST_VAL[WIDTH-1:0];
            pin_s2   <= RST_VAL[WIDTH-1:0];
            pin_s3   <= RST_VAL[WIDTH-1:0];
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2   <= pin_s1_q;
            pin_s3   <= pin_s2;
        end
    end
endmodule

// *** hdl/phmp_port.sv ***
// slave end of the 8-bit parallel host message port
// assumes the host keeps data and select stable across each strobe edge
`timescale 1ns/100ps
`include "phmp_cfg.svh"

// Overview of operation
// R1: irq pin low while outgoing message waits
// R2: control bit1 high while message pending
// R3: select 00 msg, 01 ctrl, 10/11 audio
// R4: select captured at chip select falling
// R5: single byte write stores selected register
// R6: host byte-writes never target message register
// R7: word writes only to message, select zero
// R8: four write pulses, byte per rising edge
// R9: bytes MS first, assembled into word
// R10: host ends word write raising chip select
// R11: host byte-reads only the control register
// R12: device drives bus during read strobe
// R13: device releases bus when strobes rise
// R14: unsolicited core messages also raise irq
// R15: busy set on fourth byte, cleared on take
// R16: host message read clears pending flag
// R17: host writes 11 to byte select
// R18: strobes synchronised, each edge seen once
module phmp_port (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // host pins
    input  wire logic                   host_cs_n,
    input  wire logic                   host_wr_n,
    input  wire logic                   host_rd_n,
    input  wire phmp_pkg::phmp_sel_type host_addr,
    input  wire phmp_pkg::phmp_byte_type host_data_bus_i,
    output phmp_pkg::phmp_byte_type     host_data_bus_o,
    output logic                        host_data_bus_oe,
    output logic                        message_irq_n,
    output logic                        input_word_busy,
    // core side: incoming word
    output phmp_pkg::phmp_word_type     core_in_word,
    input  wire logic                   core_in_take,
    // core side: outgoing word
    input  wire phmp_pkg::phmp_word_type core_out_word,
    input  wire logic                   core_out_load,
    // core side: audio bytes and control
    output phmp_pkg::phmp_byte_type     audio_input_one,
    output logic                        audio_one_strobe,
    output phmp_pkg::phmp_byte_type     audio_input_two,
    output logic                        audio_two_strobe,
    output logic [1:0]                  byte_sel
);
    import phmp_pkg::*;

    logic [12:0]   pin_s2;
    logic [12:0]   pin_s3;
    logic [2:0]    stb_q;
    logic [2:0]    stb_d;
    logic          cs_fall;
    logic          cs_rise;
    logic          wr_rise;
    logic          rd_fall;
    logic          rd_rise;
    logic          cs_low;
    phmp_sel_type  addr_s;
    phmp_byte_type data_s;
    phmp_sel_type  addr_q;
    logic [1:0]    wcnt_q;
    logic [1:0]    rcnt_q;
    phmp_word_type asm_q;
    logic          pend_q;
    phmp_word_type out_q;
    phmp_byte_type ctrl_val;
    logic          word_done;
    logic          msg_read_done;

    // --------------------------------------------------------------
    // pin synchronisation and edge detection
    // --------------------------------------------------------------
    phmp_sync #(
        .WIDTH   (13),
        .RST_VAL (`PHMP_PIN_RST)
    ) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .pin_raw ({host_cs_n, host_wr_n, host_rd_n, host_addr,
                   host_data_bus_i}),
        .pin_s2  (pin_s2),
        .pin_s3  (pin_s3)
    );

    assign addr_s = pin_s3[9:8];
    assign data_s = pin_s3[7:0];

    // a strobe level only counts once stages two and three agree
    always_comb begin
        stb_d = stb_q;
        for (int i = 0; i < 3; i++) begin
            if (pin_s2[10+i] == pin_s3[10+i]) begin
                stb_d[i] = pin_s3[10+i]; // [R18]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stb_q <= `PHMP_STB_IDLE;
        end else begin
            stb_q <= stb_d;
        end
    end

    // bit 2 chip select, bit 1 write, bit 0 read; one pulse per change
    assign cs_fall = stb_q[2] && !stb_d[2];
    assign cs_rise = !stb_q[2] && stb_d[2];
    assign wr_rise = !stb_q[1] && stb_d[1] && !stb_q[2];
    assign rd_fall = stb_q[0] && !stb_d[0] && !stb_d[2];
    assign rd_rise = !stb_q[0] && stb_d[0];
    assign cs_low  = !stb_q[2];

    // --------------------------------------------------------------
    // select latch and byte counters
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= `PHMP_SEL_MSG;
        end else if (cs_fall) begin
            addr_q <= addr_s; // [R4]
        end
    end

    // counters restart with every chip select so a short word resyncs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wcnt_q <= `PHMP_CNT_FIRST;
            rcnt_q <= `PHMP_CNT_FIRST;
        end else if (cs_fall) begin
            wcnt_q <= `PHMP_CNT_FIRST;
            rcnt_q <= `PHMP_CNT_FIRST;
        end else begin
            if (wr_rise && addr_q == `PHMP_SEL_MSG) begin
                wcnt_q <= wcnt_q + `PHMP_CNT_STEP; // [R8]
            end
            if (rd_rise && cs_low && addr_q == `PHMP_SEL_MSG) begin
                rcnt_q <= rcnt_q + `PHMP_CNT_STEP;
            end
        end
    end

    // --------------------------------------------------------------
    // incoming message word
    // --------------------------------------------------------------
    assign word_done = wr_rise && addr_q == `PHMP_SEL_MSG &&
                       wcnt_q == `PHMP_CNT_LAST;

    // byte lands in the lane picked by the count, MS lane first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            asm_q <= `PHMP_WORD_RST;
        end else if (wr_rise && addr_q == `PHMP_SEL_MSG) begin
            case (wcnt_q)
                2'h0:    asm_q[31:24] <= data_s; // [R9]
                2'h1:    asm_q[23:16] <= data_s; // [R9]
                2'h2:    asm_q[15:8]  <= data_s; // [R9]
                default: asm_q[7:0]   <= data_s; // [R9]
            endcase
        end
    end

    // the core sees a whole word only, never a partly written one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core_in_word <= `PHMP_WORD_RST;
        end else if (word_done) begin
            core_in_word <= {asm_q[31:8], data_s};
        end
    end

    // a new word arriving with the take keeps busy set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_word_busy <= 1'b0;
        end else if (word_done) begin
            input_word_busy <= 1'b1; // [R15]
        end else if (core_in_take) begin
            input_word_busy <= 1'b0; // [R15]
        end
    end

    // --------------------------------------------------------------
    // single byte registers
    // --------------------------------------------------------------
    // reserved bits written by the host are dropped here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            byte_sel         <= `PHMP_BSEL_RST;
            audio_input_one  <= `PHMP_BYTE_RST;
            audio_input_two  <= `PHMP_BYTE_RST;
            audio_one_strobe <= 1'b0;
            audio_two_strobe <= 1'b0;
        end else begin
            audio_one_strobe <= 1'b0;
            audio_two_strobe <= 1'b0;
            if (wr_rise && addr_q == `PHMP_SEL_CTRL) begin
                byte_sel <= data_s[`PHMP_CTL_BSEL_HI:`PHMP_CTL_BSEL_LO];
            end else if (wr_rise && addr_q == `PHMP_SEL_AUD1) begin
                audio_input_one  <= data_s; // [R5] [R3]
                audio_one_strobe <= 1'b1;
            end else if (wr_rise && addr_q == `PHMP_SEL_AUD2) begin
                audio_input_two  <= data_s; // [R5] [R3]
                audio_two_strobe <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // outgoing message and interrupt
    // --------------------------------------------------------------
    assign msg_read_done = rd_rise && cs_low &&
                           addr_q == `PHMP_SEL_MSG &&
                           rcnt_q == `PHMP_CNT_LAST;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= `PHMP_WORD_RST;
        end else if (core_out_load) begin
            out_q <= core_out_word;
        end
    end

    // a core load in the cycle of the host's last read wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
        end else if (core_out_load) begin
            pend_q <= 1'b1; // [R14]
        end else if (msg_read_done) begin
            pend_q <= 1'b0; // [R16]
        end
    end

    assign message_irq_n = !pend_q; // [R1]

    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    always_comb begin
        ctrl_val = `PHMP_BYTE_RST;
        ctrl_val[`PHMP_CTL_PEND_BIT] = pend_q; // [R2]
        ctrl_val[`PHMP_CTL_BUSY_BIT] = input_word_busy;
        ctrl_val[`PHMP_CTL_BSEL_HI:`PHMP_CTL_BSEL_LO] = byte_sel;
    end

    // write-only audio registers read back as zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_data_bus_o <= `PHMP_BYTE_RST;
        end else if (rd_fall) begin
            if (addr_q == `PHMP_SEL_CTRL) begin
                host_data_bus_o <= ctrl_val; // [R12]
            end else if (addr_q == `PHMP_SEL_MSG) begin
                case (rcnt_q)
                    2'h0:    host_data_bus_o <= out_q[31:24];
                    2'h1:    host_data_bus_o <= out_q[23:16];
                    2'h2:    host_data_bus_o <= out_q[15:8];
                    default: host_data_bus_o <= out_q[7:0];
                endcase
            end else begin
                host_data_bus_o <= `PHMP_BYTE_RST;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_data_bus_oe <= 1'b0;
        end else if (rd_rise || cs_rise) begin
            host_data_bus_oe <= 1'b0; // [R13]
        end else if (rd_fall) begin
            host_data_bus_oe <= 1'b1; // [R12]
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_irq_on_load: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        core_out_load |=> !message_irq_n)
        else $error("irq not asserted after core load");
    a_status_match: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        (rd_fall && addr_q == `PHMP_SEL_CTRL) |=>
        host_data_bus_o[`PHMP_CTL_PEND_BIT] == !$past(message_irq_n))
        else $error("pending bit disagrees with irq pin");
    a_addr_latch: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        cs_fall |=> addr_q == $past(addr_s))
        else $error("select not captured at chip select fall");
    a_audio_write: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        (wr_rise && addr_q == `PHMP_SEL_AUD1) |=>
        audio_input_one == $past(data_s) && audio_one_strobe)
        else $error("audio byte not stored");
    a_msb_first: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
        (wr_rise && addr_q == `PHMP_SEL_MSG && wcnt_q == 2'h0) |=>
        asm_q[31:24] == $past(data_s) && wcnt_q == 2'h1)
        else $error("first word byte not in top lane");
    a_busy_set: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
        word_done |=> input_word_busy &&
        core_in_word[7:0] == $past(data_s))
        else $error("busy not set after fourth byte");
    a_busy_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
        (core_in_take && !word_done) |=> !input_word_busy)
        else $error("busy not cleared by core take");
    a_read_drive: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
        (rd_fall && !rd_rise && !cs_rise) |=> host_data_bus_oe)
        else $error("bus not driven during read");
    a_read_release: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        (rd_rise || cs_rise) |=> !host_data_bus_oe [*2])
        else $error("bus still driven after strobe rise");
    a_pend_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        (msg_read_done && !core_out_load) |=> message_irq_n)
        else $error("pending not cleared by message read");
    a_edge_once: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
        wr_rise |=> !wr_rise)
        else $error("write edge seen twice");
endmodule

// *** bench/phmp_host_model.sv ***
// host controller model for the parallel host message port bench
// assumes the bench resolves the data bus from both enables
`timescale 1ns/100ps
module phmp_host_model (
    // clock
    input  wire logic       clk,
    // host pins
    output logic            cs_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic [1:0]      addr,
    output logic [7:0]      d_out,
    output logic            d_en,
    input  wire logic [7:0] d_in,
    // captured read bytes
    output logic            rd_valid,
    output logic [7:0]      rd_data
);
    // six clocks a phase: twice the minimum the synchroniser needs
    localparam int PH = 6;

    // ------------------------------------------------------------------
    // pin driving tasks, all changes at the falling clock edge
    // ------------------------------------------------------------------
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        addr = 2'h0;
        d_out = 8'h5A;
        d_en = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // select settles before chip select falls and stays for the cycle
    task automatic open_cycle(input logic [1:0] sel);
        addr = sel;
        idle(PH);
        cs_n = 1'b0;
        idle(PH);
    endtask
    // released driver holds the inverse of the last byte, not a stale copy
    task automatic close_cycle();
        cs_n = 1'b1;
        idle(PH);
        d_en = 1'b0;
        d_out = ~d_out;
        idle(PH);
    endtask
    task automatic wr_pulse(input logic [7:0] b);
        d_out = b;
        d_en = 1'b1;
        wr_n = 1'b0;
        idle(PH);
        wr_n = 1'b1;
        idle(PH);
    endtask
    task automatic wr_byte(input logic [1:0] sel, input logic [7:0] b);
        open_cycle(sel);
        wr_pulse(b);
        close_cycle();
    endtask
    // whole word in one chip select, most significant byte first
    task automatic wr_word(input logic [31:0] w);
        open_cycle(2'h0);
        for (int i = 3; i >= 0; i--) begin
            wr_pulse(w[8*i+:8]);
        end
        close_cycle();
    endtask
    // host keeps its drivers off while reading
    task automatic rd_bytes(input logic [1:0] sel, input int n);
        open_cycle(sel);
        repeat (n) begin
            rd_n = 1'b0;
            idle(PH);
            rd_data = d_in;
            rd_valid = 1'b1;
            @(negedge clk);
            rd_valid = 1'b0;
            rd_n = 1'b1;
            idle(PH - 1);
        end
        close_cycle();
    endtask
endmodule

// *** bench/phmp_port_tb_top.sv ***
// self-checking bench for the parallel host message port
// assumes phmp_pkg and phmp_host_model are compiled before it
`timescale 1ns/100ps
module phmp_port_tb_top;
    import phmp_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic           clk, rst_b, cs_n, wr_n, rd_n, h_en, rd_valid;
    logic           oe, irq_n, busy, take, load, s1, s2, busy_prev;
    phmp_sel_type   addr;
    phmp_byte_type  h_out, bus, dout, rd_data, aud1, aud2;
    logic [1:0]     byte_sel;
    phmp_word_type  in_word, out_word, w;
    logic [31:0]    seed;
    logic [31:0]    exp_q[$];
    int             err_count, n_checks;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // device drives only while enabled, then the host if it drives;
    // a bus nobody drives shows the inverse of the device's last byte
    assign bus = oe ? dout : (h_en ? h_out : ~dout);

    phmp_host_model host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .addr(addr), .d_out(h_out), .d_en(h_en), .d_in(bus),
        .rd_valid(rd_valid), .rd_data(rd_data));
    phmp_port dut (.clk(clk), .rst_b(rst_b), .host_cs_n(cs_n),
        .host_wr_n(wr_n), .host_rd_n(rd_n), .host_addr(addr),
        .host_data_bus_i(bus), .host_data_bus_o(dout),
        .host_data_bus_oe(oe), .message_irq_n(irq_n),
        .input_word_busy(busy), .core_in_word(in_word),
        .core_in_take(take), .core_out_word(out_word),
        .core_out_load(load), .audio_input_one(aud1),
        .audio_one_strobe(s1), .audio_input_two(aud2),
        .audio_two_strobe(s2), .byte_sel(byte_sel));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic take_note(input logic [31:0] got);
        logic [31:0] e;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
        `CHK(got, e)
    endtask
    // bounded wait for every noted result to show up
    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 100) begin
            @(negedge clk);
            k++;
        end
        `CHK(exp_q.size(), 0)
    endtask
    task automatic ctrl_read(input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        host.rd_bytes(2'h1, 1);
        drain();
        `CHK(oe, 1'b0)
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // result watcher: every visible result consumes the oldest note
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        busy_prev <= busy;
        if (s1) take_note({24'h0, aud1});
        if (s2) take_note({24'h0, aud2});
        if (busy && !busy_prev) take_note(in_word);
        if (rd_valid) take_note({24'h0, rd_data});
    end

    // watchdog: the whole run needs well under ten thousand clocks
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        take = 1'b0;
        load = 1'b0;
        out_word = 32'h0000_0000;
        busy_prev = 1'b0;
        seed = 32'h0000_059B;
        err_count = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(irq_n, 1'b1)
        ctrl_read(8'h18);
        $display("test reset state done");
        host.wr_byte(2'h1, 8'h08);
        `CHK(byte_sel, 2'h1)
        ctrl_read(8'h08);
        host.wr_byte(2'h1, 8'h18);
        `CHK(byte_sel, 2'h3)
        for (int i = 0; i < 4; i++) begin
            w = xs();
            exp_q.push_back({24'h0, w[7:0]});
            host.wr_byte(2'h2 + 2'(i % 2), w[7:0]);
            drain();
        end
        $display("test byte writes done");
        for (int r = 0; r < 3; r++) begin
            w = xs();
            exp_q.push_back(w);
            host.wr_word(w);
            drain();
            `CHK(busy, 1'b1)
            ctrl_read(8'h1C);
            pulse(take);
            `CHK(busy, 1'b0)
            w = xs();
            out_word = w;
            pulse(load);
            `CHK(irq_n, 1'b0)
            ctrl_read(8'h1A);
            for (int i = 3; i >= 0; i--) exp_q.push_back({24'h0, w[8*i+:8]});
            host.rd_bytes(2'h0, 4);
            drain();
            `CHK(irq_n, 1'b1)
            ctrl_read(8'h18);
        end
        $display("test message words done");
        tally_and_finish();
    end
endmodule
